// *** logic/timer_capture_regs.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef TIMER_CAPTURE_REGS_VH
`define TIMER_CAPTURE_REGS_VH

// word indices on the avalon bus (byte address = 4 * index)
`define TMR_IDX_CTRL 3'h0
`define TMR_IDX_COUNT 3'h1
`define TMR_IDX_RELOAD_A 3'h2
`define TMR_IDX_RELOAD_B 3'h3
`define TMR_IDX_IRQ_STATUS 3'h4
`define TMR_IDX_IRQ_MASK 3'h5

// control register fields
`define TMR_BIT_MODE_HI 7
`define TMR_BIT_MODE_MID 6
`define TMR_BIT_MODE_LO 5
`define TMR_BIT_RUN_UF 4
`define TMR_BIT_PEND_A 3
`define TMR_BIT_EN_A 2
`define TMR_BIT_PEND_B 1
`define TMR_BIT_EN_B 0

// interrupt status / mask fields
`define TMR_IRQ_PEND_A 0
`define TMR_IRQ_PEND_B 1
`define TMR_IRQ_UNDERFLOW 2
`define TMR_IRQ_W 3

// reset values
`define TMR_CTRL_RST 8'h00
`define TMR_WORD_RST 16'h0000
`define TMR_IRQ_RST 3'h0

// instruction cycle tick
`define TMR_CLK_PERIOD_NS 40
`define TMR_TICK_PERIOD_NS 1000
`define TMR_TICK_CYCLES (`TMR_TICK_PERIOD_NS / `TMR_CLK_PERIOD_NS)

`endif

// *** logic/tick_divider.v ***
// divider that makes the one-cycle instruction cycle tick
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter integer DIV = 25
) (
  input wire clock_i,
  input wire rst_n_i,
  output reg tick_o
);
  reg [15:0] cnt_q;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt_q == DIV[15:0] - 16'h0001)
    begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire

// *** logic/pin_edge_detect.v ***
// rising and falling edge pulses of a synchronous pin
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect (
  input wire clock_i,
  input wire rst_n_i,
  input wire pin_i,
  output wire rise_o,
  output wire fall_o
);
  reg prev_q;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_q <= 1'b0;
    else
      prev_q <= pin_i;
  end

  assign rise_o = pin_i & ~prev_q;
  assign fall_o = ~pin_i & prev_q;
endmodule // pin_edge_detect
`default_nettype wire

// *** logic/multimode_timer_capture.v ***
// multimode 16-bit timer with pwm, event counter and input capture
//
// Function
// - capture mode: counter runs on tick; reg A pairs pin A, reg B pin B.
// - on selected trigger edge, copy counter into the paired capture register.
// - pin A edge polarity chosen by the low mode bit; pin B uses falling if high or low mode bit set.
// - capture mode: pin A trigger sets pending A, pin B sets pending B.
// - interrupt A needs enable A, interrupt B needs enable B.
// - capture mode: underflow sets the run/underflow bit as pending flag.
// - capture mode: underflow interrupt gated by enable A.
// - pwm and event modes: run/underflow bit one starts, zero stops counter.
// - 101 pwm toggle, 100 pwm, 000/001 event count on pin A rising.
// - pwm counts down; first underflow reloads A, then alternate from B.
// - pwm: reload-from-A underflow sets pending A, reload-from-B sets pending B.
// - event mode counts pin A rising edges; underflow sets pending A; no pwm output.
// - event mode: pin B rising edge sets pending B.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`include "timer_capture_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module multimode_timer_capture #(
  parameter integer TICK_DIV = `TMR_TICK_CYCLES
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire timer_pin_a_i,
  output reg timer_pin_a_o,
  output reg timer_pin_a_oe_n_o,
  input wire timer_pin_b_i,
  output reg irq_a_o,
  output reg irq_b_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte lane merge

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      be_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // tick and pin edges

  wire tick;
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;

  tick_divider #(.DIV(TICK_DIV)) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_q),
    .tick_o(tick)
  );

  pin_edge_detect u_edge_a (
    .clock_i(clock_i),
    .rst_n_i(rst_n_q),
    .pin_i(timer_pin_a_i),
    .rise_o(a_rise),
    .fall_o(a_fall)
  );

  pin_edge_detect u_edge_b (
    .clock_i(clock_i),
    .rst_n_i(rst_n_q),
    .pin_i(timer_pin_b_i),
    .rise_o(b_rise),
    .fall_o(b_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] ctrl_q;
  reg [15:0] count_q;
  reg [15:0] reload_capture_reg_a_q;
  reg [15:0] reload_capture_reg_b_q;
  reg [`TMR_IRQ_W-1:0] irq_status_q;
  reg [`TMR_IRQ_W-1:0] irq_mask_q;
  reg next_from_b_q;

  wire mode_sel_hi = ctrl_q[`TMR_BIT_MODE_HI];
  wire mode_sel_mid = ctrl_q[`TMR_BIT_MODE_MID];
  wire mode_sel_lo = ctrl_q[`TMR_BIT_MODE_LO];
  wire run_or_underflow_flag = ctrl_q[`TMR_BIT_RUN_UF];
  wire pending_flag_a = ctrl_q[`TMR_BIT_PEND_A];
  wire irq_enable_a = ctrl_q[`TMR_BIT_EN_A];
  wire pending_flag_b = ctrl_q[`TMR_BIT_PEND_B];
  wire irq_enable_b = ctrl_q[`TMR_BIT_EN_B];

  // mode decode
  wire mode_pwm = mode_sel_hi & ~mode_sel_mid;
  wire mode_toggle = mode_pwm & mode_sel_lo;
  wire mode_event = ~mode_sel_hi & ~mode_sel_mid;
  wire mode_capture = mode_sel_mid;

  // bus access strobes, taken while waitrequest is low
  wire bus_wr = avs_write_i & ~avs_waitrequest_o;
  wire bus_rd = avs_read_i & ~avs_waitrequest_o;
  wire wr_ctrl = bus_wr & (avs_address_i == `TMR_IDX_CTRL) & avs_byteenable_i[0];
  wire wr_count = bus_wr & (avs_address_i == `TMR_IDX_COUNT);
  wire wr_rel_a = bus_wr & (avs_address_i == `TMR_IDX_RELOAD_A);
  wire wr_rel_b = bus_wr & (avs_address_i == `TMR_IDX_RELOAD_B);
  wire wr_mask = bus_wr & (avs_address_i == `TMR_IDX_IRQ_MASK) & avs_byteenable_i[0];
  wire rd_status = bus_rd & (avs_address_i == `TMR_IDX_IRQ_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // counting and events

  // count enable: tick in pwm and capture, pin A rising in event mode
  wire count_en = mode_capture ? tick :
    (mode_pwm ? (tick & run_or_underflow_flag) :
    (a_rise & run_or_underflow_flag));
  wire underflow = count_en & (count_q == 16'h0000);

  // capture triggers, polarity per pin
  wire trig_a = mode_capture & (mode_sel_lo ? a_fall : a_rise);
  wire trig_b = mode_capture & ((mode_sel_hi | mode_sel_lo) ? b_fall : b_rise);

  // pending sets
  wire set_a = trig_a |
    (mode_pwm & underflow & ~next_from_b_q) |
    (mode_event & underflow);
  wire set_b = trig_b |
    (mode_pwm & underflow & next_from_b_q) |
    (mode_event & b_rise);
  wire set_uf = mode_capture & underflow;

  ////////////////////////////////////////////////////////////////////////////
  // control register: hardware set wins over software clear

  reg [7:0] ctrl_d;

  always @*
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = avs_writedata_i[7:0];
    ctrl_d[`TMR_BIT_PEND_A] = ctrl_d[`TMR_BIT_PEND_A] | set_a;
    ctrl_d[`TMR_BIT_PEND_B] = ctrl_d[`TMR_BIT_PEND_B] | set_b;
    ctrl_d[`TMR_BIT_RUN_UF] = ctrl_d[`TMR_BIT_RUN_UF] | set_uf;
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ctrl_q <= `TMR_CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, reload and capture registers

  reg [31:0] count_wr;
  reg [31:0] rel_a_wr;
  reg [31:0] rel_b_wr;

  always @*
  begin
    count_wr = be_merge({16'h0000, count_q}, avs_writedata_i, avs_byteenable_i);
    rel_a_wr = be_merge({16'h0000, reload_capture_reg_a_q}, avs_writedata_i,
      avs_byteenable_i);
    rel_b_wr = be_merge({16'h0000, reload_capture_reg_b_q}, avs_writedata_i,
      avs_byteenable_i);
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      count_q <= `TMR_WORD_RST;
      next_from_b_q <= 1'b0;
    end
    else
    begin
      if (wr_count)
        count_q <= count_wr[15:0];
      else if (underflow & mode_pwm)
        count_q <= next_from_b_q ? reload_capture_reg_b_q : reload_capture_reg_a_q;
      else if (underflow & mode_event)
        count_q <= reload_capture_reg_a_q;
      else if (count_en)
        count_q <= count_q - 16'h0001;
      if (!(mode_pwm & run_or_underflow_flag))
        next_from_b_q <= 1'b0;
      else if (underflow)
        next_from_b_q <= ~next_from_b_q;
    end
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      reload_capture_reg_a_q <= `TMR_WORD_RST;
      reload_capture_reg_b_q <= `TMR_WORD_RST;
    end
    else
    begin
      if (trig_a)
        reload_capture_reg_a_q <= count_q;
      else if (wr_rel_a)
        reload_capture_reg_a_q <= rel_a_wr[15:0];
      if (trig_b)
        reload_capture_reg_b_q <= count_q;
      else if (wr_rel_b)
        reload_capture_reg_b_q <= rel_b_wr[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin A output

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      timer_pin_a_o <= 1'b0;
      timer_pin_a_oe_n_o <= 1'b1;
    end
    else
    begin
      timer_pin_a_oe_n_o <= ~mode_toggle;
      if (mode_toggle & underflow)
        timer_pin_a_o <= ~timer_pin_a_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_a_o <= 1'b0;
      irq_b_o <= 1'b0;
    end
    else
    begin
      irq_a_o <= irq_enable_a & (pending_flag_a |
        (mode_capture & run_or_underflow_flag));
      irq_b_o <= irq_enable_b & pending_flag_b;
    end
  end

  // sticky status, cleared by read, set wins
  wire [`TMR_IRQ_W-1:0] irq_events = {underflow, set_b, set_a};
  wire [`TMR_IRQ_W-1:0] rd_clear = rd_status ? avs_readdata_o[`TMR_IRQ_W-1:0] : `TMR_IRQ_RST;
  wire [`TMR_IRQ_W-1:0] irq_status_d = (irq_status_q & ~rd_clear) | irq_events;

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_status_q <= `TMR_IRQ_RST;
      irq_mask_q <= `TMR_IRQ_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      if (wr_mask)
        irq_mask_q <= avs_writedata_i[`TMR_IRQ_W-1:0];
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer

  reg [31:0] rdata_d;

  always @*
  begin
    case (avs_address_i)
      `TMR_IDX_CTRL: rdata_d = {24'h000000, ctrl_q};
      `TMR_IDX_COUNT: rdata_d = {16'h0000, count_q};
      `TMR_IDX_RELOAD_A: rdata_d = {16'h0000, reload_capture_reg_a_q};
      `TMR_IDX_RELOAD_B: rdata_d = {16'h0000, reload_capture_reg_b_q};
      `TMR_IDX_IRQ_STATUS: rdata_d = {29'h00000000, irq_status_q};
      `TMR_IDX_IRQ_MASK: rdata_d = {29'h00000000, irq_mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rdata_d;
    end
  end

endmodule // multimode_timer_capture
`default_nettype wire

// *** tb/multimode_timer_capture_props.sv ***
// bus, pin and interrupt checks for the timer
`timescale 1ns/10ps
`default_nettype none
module multimode_timer_capture_props (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic timer_pin_a_o,
  input wire logic timer_pin_a_oe_n_o,
  input wire logic irq_a_o,
  input wire logic irq_b_o,
  input wire logic irq_o
);
  logic [2:0] md_q, mk_q;
  logic ea_q, eb_q, wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  ////////////////////////////////////////////////////////////////////////////
  // shadow of mode, enables and mask
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      md_q <= 3'h0;
      ea_q <= 1'b0;
      eb_q <= 1'b0;
      mk_q <= 3'h0;
    end
    else if (wr_ok && avs_address_i == 3'h0)
    begin
      md_q <= avs_writedata_i[7:5];
      ea_q <= avs_writedata_i[2];
      eb_q <= avs_writedata_i[0];
    end
    else if (wr_ok && avs_address_i == 3'h5)
      mk_q <= avs_writedata_i[2:0];
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_wait_one: assert property (s_req |=> s_ack)
    else $error("bus answer not one wait cycle");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i[2:1] == 2'h3 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_oe_pwm_only: assert property (md_q != 3'h5 && $past(md_q) != 3'h5 |-> timer_pin_a_oe_n_o)
    else $error("pin a driven outside toggle mode");
  a_pin_a_still: assert property ($changed(timer_pin_a_o)
    |-> md_q == 3'h5 || $past(md_q) == 3'h5)
    else $error("pin a moved outside toggle mode");
  a_irq_a_gate: assert property (!ea_q && !$past(ea_q) |-> !irq_a_o)
    else $error("irq a without enable");
  a_irq_b_gate: assert property (!eb_q && !$past(eb_q) |-> !irq_b_o)
    else $error("irq b without enable");
  a_irq_mask_gate: assert property (mk_q == 3'h0 && $past(mk_q) == 3'h0 |-> !irq_o)
    else $error("irq with all sources masked");
endmodule // multimode_timer_capture_props
`default_nettype wire

// *** tb/pin_source.sv ***
// outside world driving the two timer pins
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input wire logic clock_i,
  input wire logic lvl_a_i,
  input wire logic lvl_b_i,
  input wire logic drv_a_i,
  input wire logic oe_n_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  always @(posedge clock_i)
  begin
    a_q <= lvl_a_i;
    b_q <= lvl_b_i;
  end
  // pin a follows the timer while it drives
  assign pin_a_o = oe_n_i ? a_q : drv_a_i;
  assign pin_b_o = b_q;
endmodule // pin_source
`default_nettype wire

// *** tb/multimode_timer_capture_tb.sv ***
// self-checking bench for the multimode timer
`timescale 1ns/10ps
`default_nettype none
module multimode_timer_capture_tb;
  localparam integer TD = 4;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] avs_address_i = 3'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd, c0;
  logic avs_waitrequest_o, pin_a_o, oe_n, pin_a, pin_b, irq_a_o, irq_b_o, irq_o;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  int bad_count = 0;
  int compares = 0;
  always #20 clock_i = ~clock_i;
  multimode_timer_capture #(.TICK_DIV(TD)) i_multimode_timer_capture (.clock_i, .arst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
    .avs_readdata_o, .avs_waitrequest_o, .timer_pin_a_i(pin_a), .timer_pin_a_o(pin_a_o),
    .timer_pin_a_oe_n_o(oe_n), .timer_pin_b_i(pin_b), .irq_a_o, .irq_b_o, .irq_o);
  pin_source i_pin_source (.clock_i, .lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .drv_a_i(pin_a_o),
    .oe_n_i(oe_n), .pin_a_o(pin_a), .pin_b_o(pin_b));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
  begin
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clock_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  end
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [2:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  end
  endtask
  task pins(input logic a, input logic b);
  begin
    @(posedge clock_i);
    lvl_a <= a;
    lvl_b <= b;
    repeat (8) @(posedge clock_i);
  end
  endtask
  task wait_tgl(output int n);
    logic v;
  begin
    v = pin_a_o;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pin_a_o === v);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
  begin
    for (int i = 0; i < 8; i++)
      rdc(i[2:0], 32'h0);
    chk(oe_n, 1'b1);
  end
  endtask
  task t_pwm;
    int n;
  begin
    wr(3'h2, 32'h3);
    wr(3'h3, 32'h5);
    wr(3'h1, 32'h1);
    wr(3'h0, 32'hB5);
    wait_tgl(n);
    wait_tgl(n);
    chk(n, 4 * TD);
    wait_tgl(n);
    chk(n, 6 * TD);
    chk({irq_a_o, irq_b_o}, 2'h3);
    chk(oe_n, 1'b0);
    rdc(3'h0, 32'hBF);
    wr(3'h0, 32'hAF);
    chk(irq_o, 1'b0);
    wr(3'h5, 32'h7);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b1);
    rdc(3'h4, 32'h7);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b0);
    bus(1'b0, 3'h1, 32'h0);
    c0 = rd;
    repeat (3 * TD) @(posedge clock_i);
    rdc(3'h1, c0);
    rdc(3'h4, 32'h0);
    rdc(3'h0, 32'hAF);
    wr(3'h0, 32'hA5);
    repeat (3) @(posedge clock_i);
    chk(irq_a_o, 1'b0);
    c0 = pin_a_o;
    wr(3'h0, 32'h95);
    repeat (12 * TD) @(posedge clock_i);
    rdc(3'h0, 32'h9F);
    chk(oe_n, 1'b1);
    chk(pin_a_o, c0[0]);
  end
  endtask
  task t_cap;
    logic pa, pb;
  begin
    wr(3'h1, 32'hF000);
    for (int i = 0; i < 4; i++)
    begin
      pa = !i[1];
      pb = (i == 0);
      pins(pa, pb);
      wr(3'h0, {24'h0, i[0], 1'b1, i[1], 5'h0});
      pins(!pa, !pb);
      rdc(3'h0, {24'h0, i[0], 1'b1, i[1], 5'h0});
      bus(1'b0, 3'h1, 32'h0);
      c0 = rd;
      pins(pa, pb);
      rdc(3'h0, {24'h0, i[0], 1'b1, i[1], 5'h0A});
      bus(1'b0, 3'h2, 32'h0);
      chk((c0[15:0] - rd[15:0]) < 16'h3, 1'b1);
      bus(1'b0, 3'h3, 32'h0);
      chk((c0[15:0] - rd[15:0]) < 16'h3, 1'b1);
    end
    wr(3'h1, 32'h2);
    wr(3'h0, 32'h44);
    repeat (5 * TD) @(posedge clock_i);
    rdc(3'h0, 32'h54);
    chk(irq_a_o, 1'b1);
    wr(3'h0, 32'h44);
    repeat (3) @(posedge clock_i);
    chk(irq_a_o, 1'b0);
  end
  endtask
  task t_evt;
  begin
    for (int i = 0; i < 2; i++)
    begin
      wr(3'h2, 32'h2);
      wr(3'h0, {26'h0, i[0], 5'h10});
      wr(3'h1, 32'h2);
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      repeat (3 * TD) @(posedge clock_i);
      rdc(3'h1, 32'h1);
      repeat (2)
      begin
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
      end
      rdc(3'h0, {26'h0, i[0], 5'h18});
      chk(oe_n, 1'b1);
      pins(1'b0, 1'b1);
      rdc(3'h0, {26'h0, i[0], 5'h1A});
      pins(1'b0, 1'b0);
    end
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
  begin
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset;
    t_pwm;
    t_cap;
    t_evt;
    wrap_up;
  end
endmodule // multimode_timer_capture_tb
bind multimode_timer_capture multimode_timer_capture_props i_multimode_timer_capture_props (
  .clock_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .timer_pin_a_o,
  .timer_pin_a_oe_n_o, .irq_a_o, .irq_b_o, .irq_o);
`default_nettype wire
